// *** rtl/sub_unit_consts.svh ***
`ifndef SUB_UNIT_CONSTS_SVH
`define SUB_UNIT_CONSTS_SVH

`define LIT_OP_UPPER     8'h08
`define FILE_OP_UPPER    6'h17
`define OP_DEST_BIT      9
`define OP_ACCESS_BIT    8
`define LIT_OFFSET_MAX   8'h5f
`define ACC_RESET        8'h00
`define FLAG_NEG_BIT     4
`define FLAG_OV_BIT      3
`define FLAG_ZERO_BIT    2
`define FLAG_DC_BIT      1
`define FLAG_CARRY_BIT   0

`endif

// *** rtl/sub_unit_pkg.sv ***
package sub_unit_pkg;
  typedef struct packed {
    logic neg;
    logic overflow_flag;
    logic zero;
    logic digit_carry_flag;
    logic carry;
  } alu_flags_s;

  typedef struct packed {
    logic       we;
    logic [7:0] addr;
    logic [7:0] data;
  } mem_write_s;

  typedef struct packed {
    logic       indexed;
    logic       banked;
    logic [7:0] addr;
  } file_addr_s;
endpackage

// *** rtl/subtract_instruction_unit.sv ***
// Functional notes
// [RL1] opcode 0000 1000 kkkkkkkk: literal minus accumulator into accumulator, flags updated
// [RL2] file subtract: data byte minus accumulator, flags updated from the result
// [RL3] opcode 0101 11da ffffffff: d clear writes accumulator, d set writes byte
// [RL4] extended set, access bank, address up to 95: indexed literal offset address
// [RL5] carry set when no borrow; negative is bit 7; zero when all zeros
`timescale 1ns/1ps
`include "sub_unit_consts.svh"

module subtract_instruction_unit
  import sub_unit_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        resetn_i,
  input  wire logic        op_valid_i,
  input  wire logic [15:0] opcode_i,
  input  wire logic        ext_set_i,
  input  wire logic [7:0]  file_data_i,
  output      logic [7:0]  acc_o,
  output      alu_flags_s  flags_o,
  output      mem_write_s  mem_wr_o,
  output      file_addr_s  file_addr_o,
  output      logic        done_o
);

  logic [7:0] acc_reg;
  alu_flags_s flags_reg;
  logic       we_reg;
  logic [7:0] wr_addr_reg;
  logic [7:0] wr_data_reg;
  logic [7:0] fa_addr_reg;
  logic       fa_banked_reg;
  logic       fa_indexed_reg;
  logic       done_reg;

  logic [7:0] acc_next;
  alu_flags_s flags_next;
  logic       we_next;
  logic [7:0] wr_addr_next;
  logic [7:0] wr_data_next;
  logic [7:0] fa_addr_next;
  logic       fa_banked_next;
  logic       fa_indexed_next;
  logic       done_next;

  // borrow out reported inverted, the way the carry flag reads
  function automatic logic no_borrow8(input logic [7:0] a, input logic [7:0] b);
    logic [8:0] diff;
    diff = {1'b0, a} - {1'b0, b};
    return ~diff[8];
  endfunction

  function automatic logic no_borrow4(input logic [3:0] a, input logic [3:0] b);
    logic [4:0] diff;
    diff = {1'b0, a} - {1'b0, b};
    return ~diff[4];
  endfunction

  // signed overflow: operands differ in sign and result sign flips from a
  function automatic logic sub_overflow(input logic [7:0] a, input logic [7:0] b);
    logic [7:0] diff;
    diff = a - b;
    return (a[7] ^ b[7]) & (a[7] ^ diff[7]);
  endfunction

  function automatic alu_flags_s sub_flags(input logic [7:0] a, input logic [7:0] b);
    logic [7:0] diff;
    alu_flags_s f;
    diff               = a - b;
    f.carry            = no_borrow8(a, b); // [RL5]
    f.digit_carry_flag = no_borrow4(a[3:0], b[3:0]);
    f.neg              = diff[7]; // [RL5]
    f.zero             = (diff == 8'h00); // [RL5]
    f.overflow_flag    = sub_overflow(a, b);
    return f;
  endfunction

  // opcode decoders, shared by the update paths below
  function automatic logic lit_decode(input logic [15:0] op);
    return op[15:8] == `LIT_OP_UPPER; // [RL1]
  endfunction

  function automatic logic file_decode(input logic [15:0] op);
    return op[15:10] == `FILE_OP_UPPER; // [RL3]
  endfunction

  function automatic logic file_to_mem(input logic [15:0] op);
    return op[`OP_DEST_BIT]; // [RL3]
  endfunction

  function automatic logic offset_window(input logic [15:0] op, input logic ext);
    return ext && !op[`OP_ACCESS_BIT] && (op[7:0] <= `LIT_OFFSET_MAX); // [RL4]
  endfunction

  logic       is_lit;
  logic       is_file;
  logic       file_wr;
  logic [7:0] lit_diff;
  logic [7:0] file_diff;
  alu_flags_s lit_flags;
  alu_flags_s file_flags;

  assign is_lit     = op_valid_i && lit_decode(opcode_i); // [RL1]
  assign is_file    = op_valid_i && file_decode(opcode_i); // [RL3]
  assign file_wr    = is_file && file_to_mem(opcode_i); // [RL3]
  assign lit_diff   = opcode_i[7:0] - acc_reg; // [RL1]
  assign file_diff  = file_data_i - acc_reg; // [RL2]
  assign lit_flags  = sub_flags(opcode_i[7:0], acc_reg); // [RL1]
  assign file_flags = sub_flags(file_data_i, acc_reg); // [RL2]

  // file data is taken combinationally in the cycle the opcode is valid
  always_comb begin
    acc_next = acc_reg;
    if (is_lit) begin
      acc_next = lit_diff; // [RL1]
    end else if (is_file && !file_wr) begin
      acc_next = file_diff; // [RL3]
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      acc_reg <= `ACC_RESET;
    end else begin
      acc_reg <= acc_next;
    end
  end

  // flags stand between recognised ops
  always_comb begin
    flags_next = flags_reg;
    if (is_lit) begin
      flags_next = lit_flags; // [RL1]
    end else if (is_file) begin
      flags_next = file_flags; // [RL2]
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      flags_reg <= '0;
    end else begin
      flags_reg <= flags_next;
    end
  end

  // strobe kept apart from payload; payload follows the opcode every cycle
  always_comb begin
    we_next      = file_wr; // [RL3]
    wr_addr_next = opcode_i[7:0];
    wr_data_next = file_diff;
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      we_reg <= 1'b0;
    end else begin
      we_reg <= we_next;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wr_addr_reg <= 8'h00;
      wr_data_reg <= 8'h00;
    end else begin
      wr_addr_reg <= wr_addr_next;
      wr_data_reg <= wr_data_next;
    end
  end

  // indexed addressing only reported; bank and index resolution sit outside
  always_comb begin
    fa_addr_next    = opcode_i[7:0];
    fa_banked_next  = opcode_i[`OP_ACCESS_BIT];
    fa_indexed_next = is_file && offset_window(opcode_i, ext_set_i); // [RL4]
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      fa_addr_reg   <= 8'h00;
      fa_banked_reg <= 1'b0;
    end else begin
      fa_addr_reg   <= fa_addr_next;
      fa_banked_reg <= fa_banked_next;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      fa_indexed_reg <= 1'b0;
    end else begin
      fa_indexed_reg <= fa_indexed_next;
    end
  end

  // done is a one-cycle pulse; back-to-back ops keep it high
  always_comb begin
    done_next = is_lit || is_file;
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      done_reg <= 1'b0;
    end else begin
      done_reg <= done_next;
    end
  end

  assign acc_o       = acc_reg;
  assign flags_o     = flags_reg;
  assign mem_wr_o    = {we_reg, wr_addr_reg, wr_data_reg};
  assign file_addr_o = {fa_indexed_reg, fa_banked_reg, fa_addr_reg};
  assign done_o      = done_reg;

endmodule // subtract_instruction_unit

// *** verif/sub_unit_properties.sv ***
`timescale 1ns/1ps
module sub_chk import sub_unit_pkg::*; (input logic clk_i, resetn_i, op_valid_i, ext_set_i, done_o,
  input logic [15:0] opcode_i, input logic [7:0] file_data_i, acc_o, input alu_flags_s flags_o,
  input mem_write_s mem_wr_o, input file_addr_s file_addr_o);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  sequence s_l; op_valid_i && opcode_i[15:8] == 8'h08; endsequence
  sequence s_f; op_valid_i && opcode_i[15:10] == 6'h17; endsequence
  property p_l; logic [7:0] d; logic c;
    (s_l, d = opcode_i[7:0] - acc_o, c = opcode_i[7:0] >= acc_o) |=> acc_o == d && flags_o.carry == c;
  endproperty
  a_l: assert property (p_l) else $error("literal op");
  property p_f; logic [7:0] d; logic b;
    (s_f, d = file_data_i - acc_o, b = opcode_i[9]) |=> mem_wr_o.we == b && (b ? mem_wr_o.data : acc_o) == d;
  endproperty
  a_f: assert property (p_f) else $error("file op");
  property p_x; logic x;
    (s_f, x = ext_set_i && !opcode_i[8] && opcode_i[7:0] <= 8'h5f) |=> file_addr_o.indexed == x;
  endproperty
  a_x: assert property (p_x) else $error("indexed");
  property p_z; done_o |-> flags_o.zero == ((mem_wr_o.we ? mem_wr_o.data : acc_o) == 8'h00); endproperty
  a_z: assert property (p_z) else $error("zero");
  // opcodes with upper byte below 08 must leave the accumulator alone
  property p_i; op_valid_i && opcode_i[15:8] < 8'h08 |=> !done_o && $stable(acc_o); endproperty
  a_i: assert property (p_i) else $error("ignored op");
endmodule // sub_chk
bind subtract_instruction_unit sub_chk u_chk(.*);

// *** verif/test_subtract_instruction_unit.sv ***
`timescale 1ns/1ps
module test_subtract_instruction_unit import sub_unit_pkg::*;;
  logic clk_i = 0, resetn_i = 0, op_valid_i = 0, ext_set_i = 0, done_o;
  logic [15:0] opcode_i = 0;
  logic [7:0] file_data_i = 0, acc_o, w = 0, a, r;
  alu_flags_s flags_o;
  mem_write_s mem_wr_o;
  file_addr_s file_addr_o;
  int failures = 0, total_checks = 0, cyc = 0;
  subtract_instruction_unit u_dut(.*);
  initial forever #10 clk_i = ~clk_i;
  always @(posedge clk_i) if (++cyc > 900) begin failures++; summarize(); end
  task summarize;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task chk(input logic [16:0] s, e);
    total_checks++;
    if (s !== e) begin failures++; $display("mismatch %0t got %h want %h", $time, s, e); end
  endtask
  task op(input logic [15:0] o, input logic [7:0] f);
    opcode_i <= o; file_data_i <= f; op_valid_i <= 1; a = o[14] ? f : o[7:0]; r = a - w;
    @(posedge clk_i); #1;
    chk(done_o, 1);
    chk(flags_o, {r[7], a[7] != w[7] && r[7] != a[7], r == 0, a[3:0] >= w[3:0], a >= w});
    chk(mem_wr_o.we, o[14] && o[9]);
    if (o[14] && o[9]) chk(mem_wr_o, {1'b1, o[7:0], r});
    else begin chk(acc_o, r); w = r; end
    if (o[14]) chk(file_addr_o, {ext_set_i && !o[8] && o[7:0] <= 8'h5f, o[8], o[7:0]});
  endtask
  initial begin
    void'($urandom(27));
    repeat (6) @(posedge clk_i);
    #1 resetn_i = 1;
    for (int i = 0; i < 60; i++) begin
      ext_set_i = 1'($urandom);
      op(i[0] ? {6'h17, 10'($urandom)} : {8'h08, 8'($urandom)}, 8'($urandom));
    end
    $display("random test done");
    ext_set_i = 1;
    op(16'h5c5f, 8'h00); op(16'h5c60, 8'h00); opcode_i <= 16'h0500;
    @(posedge clk_i); #1 chk(done_o, 0);
    chk(acc_o, w);
    $display("edge test done");
    summarize();
  end
endmodule // test_subtract_instruction_unit
